// >>> rtl/text_video_pkg.sv
// constants and types shared by the character ram and dot generator
package text_video_pkg;

   // system clock and derived rates
   localparam int SYS_CLK_MHZ = 100;
   localparam int SYS_PERIOD_NS = 10;
   localparam int DOT_CLK_MHZ = 12;
   localparam int CHAR_CLK_MHZ = 2;
   localparam int DOTS_PER_CHAR = DOT_CLK_MHZ / CHAR_CLK_MHZ;

   // dot enable is a fractional divider: add the dot rate, wrap at the system rate
   localparam logic [6:0] DOT_ACC_STEP = 7'(DOT_CLK_MHZ);
   localparam logic [6:0] DOT_ACC_MOD = 7'(SYS_CLK_MHZ);
   localparam logic [6:0] DOT_ACC_RESET = 7'h00;
   localparam logic [2:0] DOT_LAST = 3'(DOTS_PER_CHAR - 1);
   localparam logic [2:0] DOT_HALF = 3'(DOTS_PER_CHAR / 2);

   // load strobe width, a least time so rounded up
   localparam int LOAD_PULSE_NS = 20;
   localparam int LOAD_PULSE_CYCLES = (LOAD_PULSE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam logic [1:0] LOAD_PULSE_CNT = 2'(LOAD_PULSE_CYCLES);

   // character memory geometry
   localparam int BANK_WORDS = 1024;
   localparam int BANK_COUNT = 2;
   localparam int ADDR_W = 11;
   localparam int CODE_W = 7;
   localparam int ROW_W = 4;

   // serializer stages, bit 7 is the first-shifted stage
   localparam int SER_FIRST = 7;
   localparam int ROM_DOT_HI = 7;
   localparam int ROM_DOT_LO = 3;

   // clock source choices
   typedef enum logic [1:0] {
      SRC_LOCAL = 2'h0,
      SRC_PHI2_2MHZ = 2'h1,
      SRC_EXTERNAL = 2'h2,
      SRC_NONE = 2'h3
   } clk_src_t;

   // every pin-side input except reset and glyph rom data, synchronised as one group
   typedef struct packed {
      logic phi2;
      logic ext2;
      logic ext12;
      logic [1:0] src;
      logic inv;
      logic sel_n;
      logic rw_n;
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic [ADDR_W-1:0] scan;
      logic [ROW_W-1:0] row;
      logic de;
      logic cu;
   } pins_t;

endpackage

// >>> rtl/text_char_ram_and_dot_generator.sv
// shared character ram, glyph lookup and six-dot serializer for a text display
//
// Summary of operation
// - local character clock realigns on every edge of the inverted host phase-two clock.
// - with a 2 MHz phase-two clock, its inverse is the character clock.
// - with external clocks selected, inverted external 2 MHz is the character clock.
// - one low load strobe of about 20 ns per character period.
// - dot rate locked to the load strobe, or taken from external 12 MHz.
// - character memory is two banks of 1024 bytes, 11-bit address.
// - host window only while ram select low; enable gates delayed inverted phase-two with char clock.
// - in host window, host address feeds ram; read/write drives write strobe and direction.
// - host write stores the byte; host read returns the addressed byte.
// - outside host windows, scan address feeds ram and writing is inhibited.
// - low seven ram bits latch as the code on character clock rise.
// - latch bit eight holds display active, delayed by one character time.
// - glyph rom address is code on bits 4 to 10 and row index.
// - load puts five dots in middle stages, zeros in lowest two and first.
// - shift on dot clock from the first stage; six bits per character.
// - serial dot gated by delayed display active and inverted, low means lit.
// - display active, no cursor, normal polarity gives a high polarity gate.
// - cursor high inverts the dot stream for that character.
// - with inversion selected the gate is low except while cursor is high.
`timescale 1ns/1ps
`default_nettype none

module text_char_ram_and_dot_generator
   import text_video_pkg::*;
#(
   parameter int BANKS = BANK_COUNT,
   parameter int WORDS = BANK_WORDS
)
(
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic i_host_phi2,
   input wire logic i_ext_clk_2mhz,
   input wire logic i_ext_clk_12mhz,
   input wire logic [1:0] i_clock_source_select,
   input wire logic i_video_invert_select,
   input wire logic i_char_ram_select_n,
   input wire logic i_host_read_write_n,
   input wire logic [ADDR_W-1:0] i_host_addr,
   input wire logic [7:0] i_host_data,
   output logic [7:0] o_host_data,
   output logic o_host_data_oe,
   output logic o_host_buffer_enable_n,
   output logic o_ram_write_n,
   input wire logic [ADDR_W-1:0] i_scan_char_address,
   input wire logic [ROW_W-1:0] i_row_line_index,
   input wire logic i_display_active,
   input wire logic i_cursor_active,
   output logic [ADDR_W-1:0] o_glyph_rom_addr,
   input wire logic [7:0] i_glyph_rom_data,
   output logic o_char_clk,
   output logic o_dot_tick,
   output logic o_dot_load_strobe_n,
   output logic o_serial_dot_out,
   output logic o_video_dot_n,
   output logic o_polarity_gate,
   output logic o_video_white
);

   typedef struct packed {
      pins_t meta;
      pins_t sync;
      logic phi2_d;
      logic ext2_d;
      logic ext12_d;
      logic nphi2_dly;
      logic [6:0] acc;
      logic [2:0] dot_cnt;
      logic char_clk;
      logic char_tick;
      logic dot_tick;
      logic [1:0] strobe_cnt;
      logic [CODE_W-1:0] code;
      logic de_pipe;
      logic de_latched;
      logic [7:0] shifter;
      logic [7:0] host_rdata;
      logic dot_n;
      logic gate;
      logic white;
   } state_t;

   state_t st;
   state_t next_st;

   logic [7:0] mem [0:BANKS-1][0:WORDS-1];
   logic [7:0] ram_q;
   logic [ADDR_W-1:0] ram_addr;
   logic host_window;
   logic ram_we;

   function automatic logic rose(input logic now, input logic was);
      rose = now & ~was;
   endfunction

   function automatic logic fell(input logic now, input logic was);
      fell = ~now & was;
   endfunction

   // the host window opens only in the high half of the character clock,
   // so scan fetches always own the ram around the latch edge
   // window gating
   assign host_window = ~st.sync.sel_n & st.nphi2_dly & st.char_clk;
   assign ram_addr = host_window ? st.sync.addr : st.sync.scan;
   assign o_ram_write_n = host_window ? st.sync.rw_n : 1'b1;
   assign ram_we = ~o_ram_write_n;
   assign o_host_buffer_enable_n = ~host_window;
   assign o_host_data_oe = host_window & st.sync.rw_n;

   // two banks chosen by the top address bit
   // store or fetch the addressed byte
   always_ff @(posedge i_sys_clk)
   begin
      if (ram_we)
      begin
         mem[ram_addr[ADDR_W-1]][ram_addr[ADDR_W-2:0]] <= st.sync.wdata;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         ram_q <= 8'h00;
      end
      else
      begin
         ram_q <= mem[ram_addr[ADDR_W-1]][ram_addr[ADDR_W-2:0]];
      end
   end

   always_comb
   begin
      logic [6:0] sum;
      logic wrap;
      logic ctick;
      logic dtick;
      logic load;
      pins_t s;
      next_st = st;
      s = st.sync;
      sum = st.acc + DOT_ACC_STEP;
      wrap = (sum >= DOT_ACC_MOD);
      ctick = 1'b0;
      dtick = 1'b0;
      load = 1'b0;
      next_st.meta = '{phi2: i_host_phi2, ext2: i_ext_clk_2mhz, ext12: i_ext_clk_12mhz,
                       src: i_clock_source_select, inv: i_video_invert_select,
                       sel_n: i_char_ram_select_n, rw_n: i_host_read_write_n,
                       addr: i_host_addr, wdata: i_host_data, scan: i_scan_char_address,
                       row: i_row_line_index, de: i_display_active, cu: i_cursor_active};
      next_st.sync = st.meta;
      next_st.phi2_d = s.phi2;
      next_st.ext2_d = s.ext2;
      next_st.ext12_d = s.ext12;
      next_st.nphi2_dly = ~s.phi2;

      case (clk_src_t'(s.src))
         SRC_LOCAL:
         begin
            if (s.phi2 != st.phi2_d)
            begin
               ctick = 1'b1;
               // the sixth dot lands on the resync edge, so it still counts
               dtick = wrap;
            end
            else if (wrap)
            begin
               dtick = 1'b1;
               ctick = (st.dot_cnt == DOT_LAST);
            end
         end
         SRC_PHI2_2MHZ:
         begin
            ctick = fell(s.phi2, st.phi2_d);
            dtick = wrap;
         end
         SRC_EXTERNAL:
         begin
            ctick = fell(s.ext2, st.ext2_d);
            dtick = rose(s.ext12, st.ext12_d);
         end
         default:
         begin
            // unassigned link setting: clocks stop, display freezes on whatever dot the serializer holds
            ctick = 1'b0;
            dtick = 1'b0;
         end
      endcase

      // local dot phase restarts with each load
      if (ctick)
      begin
         next_st.acc = DOT_ACC_RESET;
         next_st.dot_cnt = 3'h0;
      end
      else
      begin
         if (clk_src_t'(s.src) != SRC_EXTERNAL)
         begin
            next_st.acc = wrap ? 7'(sum - DOT_ACC_MOD) : sum;
         end
         if (dtick)
         begin
            next_st.dot_cnt = (st.dot_cnt == DOT_LAST) ? 3'h0 : st.dot_cnt + 3'h1;
         end
      end

      case (clk_src_t'(s.src))
         SRC_LOCAL: next_st.char_clk = (next_st.dot_cnt < DOT_HALF);
         SRC_PHI2_2MHZ: next_st.char_clk = ~s.phi2;
         SRC_EXTERNAL: next_st.char_clk = ~s.ext2;
         default: next_st.char_clk = st.char_clk;
      endcase
      next_st.char_tick = ctick;
      next_st.dot_tick = dtick;

      // strobe low for the load pulse width
      if (ctick)
      begin
         next_st.strobe_cnt = LOAD_PULSE_CNT;
      end
      else if (st.strobe_cnt != 2'h0)
      begin
         next_st.strobe_cnt = st.strobe_cnt - 2'h1;
      end

      if (ctick)
      begin
         // low seven bits form the code
         next_st.code = ram_q[CODE_W-1:0];
         next_st.de_pipe = s.de;
         next_st.de_latched = st.de_pipe;
      end

      // loading at the end of the strobe gives the glyph rom time to settle
      load = (st.strobe_cnt == 2'h1);
      if (load)
      begin
         // zeros at both ends, dots in the middle
         next_st.shifter = {1'b0, i_glyph_rom_data[ROM_DOT_HI:ROM_DOT_LO], 2'b00};
      end
      else if (dtick)
      begin
         next_st.shifter = {st.shifter[6:0], 1'b0};
      end

      if (host_window && s.rw_n)
      begin
         next_st.host_rdata = ram_q;
      end

      // gated and inverted, low is a lit dot
      next_st.dot_n = ~(st.shifter[SER_FIRST] & st.de_latched);
      // normal polarity, no cursor gives high
      // inversion leaves only the cursor high
      next_st.gate = s.inv ? s.cu : ~s.cu;
      next_st.white = next_st.dot_n ^ next_st.gate;
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         st <= '0;
         st.nphi2_dly <= 1'b0;
         st.dot_n <= 1'b1;
         st.white <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign o_host_data = st.host_rdata;
   // code on upper address bits, row on the low four
   assign o_glyph_rom_addr = {st.code, st.sync.row};
   assign o_char_clk = st.char_clk;
   assign o_dot_tick = st.dot_tick;
   assign o_dot_load_strobe_n = (st.strobe_cnt == 2'h0);
   assign o_serial_dot_out = st.shifter[SER_FIRST];
   assign o_video_dot_n = st.dot_n;
   assign o_polarity_gate = st.gate;
   assign o_video_white = st.white;

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_arst_n);

   sequence strobe_low_two;
      !o_dot_load_strobe_n [*2] ##1 o_dot_load_strobe_n;
   endsequence

   sequence serializer_loaded;
      st.strobe_cnt == 2'h1;
   endsequence

   strobe_width_a: assert property ($fell(o_dot_load_strobe_n) |-> strobe_low_two)
      else $error("load strobe not two cycles low");

   strobe_cause_a: assert property ($fell(o_dot_load_strobe_n) |-> $past(st.char_tick) == 1'b0 && st.char_tick)
      else $error("load strobe without a character tick");

   local_resync_a: assert property ((st.sync.src == SRC_LOCAL && st.sync.phi2 != st.phi2_d) |=> st.char_tick && st.dot_cnt == 3'h0)
      else $error("local clock missed phase-two resync");

   phi2_clock_a: assert property ((st.sync.src == SRC_PHI2_2MHZ && $past(st.sync.src) == SRC_PHI2_2MHZ) |=> o_char_clk == !$past(st.sync.phi2))
      else $error("character clock is not inverted phase-two");

   ext_tick_a: assert property ((st.sync.src == SRC_EXTERNAL && !st.sync.ext2 && st.ext2_d) |=> st.char_tick)
      else $error("external clock fall gave no character tick");

   ext_dot_a: assert property ((st.sync.src == SRC_EXTERNAL && st.sync.ext12 && !st.ext12_d) |=> st.dot_tick)
      else $error("external dot edge gave no dot tick");

   window_select_a: assert property (st.sync.sel_n |-> o_host_buffer_enable_n && !o_host_data_oe)
      else $error("host window open without ram select");

   host_route_a: assert property (!o_host_buffer_enable_n |-> ram_addr == st.sync.addr && o_ram_write_n == st.sync.rw_n)
      else $error("host window not routing host address");

   host_write_a: assert property ((!o_host_buffer_enable_n && !st.sync.rw_n) ##1 (ram_addr == $past(ram_addr) && o_host_buffer_enable_n == 1'b0) |=> ram_q == $past(st.sync.wdata, 2))
      else $error("host write not stored");

   scan_no_write_a: assert property (o_host_buffer_enable_n |-> o_ram_write_n && ram_addr == st.sync.scan)
      else $error("scan refresh can modify memory");

   code_latch_a: assert property (st.char_tick |-> st.code == $past(ram_q[CODE_W-1:0]))
      else $error("character code not latched from ram");

   de_delay_a: assert property (st.char_tick |-> st.de_latched == $past(st.de_pipe) && st.de_pipe == $past(st.sync.de))
      else $error("display active not delayed one character");

   rom_addr_a: assert property (st.char_tick |-> o_glyph_rom_addr[ADDR_W-1:ROW_W] == $past(ram_q[CODE_W-1:0]))
      else $error("glyph rom address lacks latched code");

   load_zeros_a: assert property (serializer_loaded |=> !st.shifter[SER_FIRST] && st.shifter[1:0] == 2'b00 && st.shifter[6:2] == $past(i_glyph_rom_data[7:3]))
      else $error("serializer load pattern wrong");

   shift_step_a: assert property ((st.dot_tick && $past(st.strobe_cnt) != 2'h1) |-> st.shifter == {$past(st.shifter[6:0]), 1'b0})
      else $error("serializer did not shift on dot tick");

   six_dots_a: assert property ((st.dot_tick && !st.char_tick) |-> st.dot_cnt != 3'h0 || $past(st.dot_cnt) == DOT_LAST)
      else $error("dot count ran past one character");

   dot_gate_a: assert property (!st.de_latched |=> o_video_dot_n)
      else $error("dot shown while display inactive");

   normal_gate_a: assert property ((!st.sync.inv && !st.sync.cu) |=> o_polarity_gate)
      else $error("normal polarity gate not high");

   cursor_flip_a: assert property ((st.sync.cu && !st.sync.inv) |=> !o_polarity_gate ##0 o_video_white == o_video_dot_n)
      else $error("cursor did not invert dots");

   invert_gate_a: assert property ((st.sync.inv && !st.sync.cu) |=> !o_polarity_gate)
      else $error("inverted polarity gate not low");

endmodule

`default_nettype wire

// >>> testbench/glyph_rom_model.sv
// glyph rom model answering the dot generator's row lookups
`timescale 1ns/1ps
`default_nettype none

module glyph_rom_model
(
   input wire logic [10:0] i_addr,
   output logic [7:0] o_data
);
   // a fixed scramble of the low eight address bits, so neighbouring codes never share a dot pattern
   assign o_data = i_addr[7:0] ^ 8'ha5;
endmodule

`default_nettype wire

// >>> testbench/text_char_ram_and_dot_generator_tb_top.sv
// self-checking bench for the character ram and dot generator
`timescale 1ns/1ps
`default_nettype none

module text_char_ram_and_dot_generator_tb_top;
   import text_video_pkg::*;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic phi2 = 1'b0;
   logic ext2 = 1'b0;
   logic ext12 = 1'b0;
   logic [1:0] src = 2'h0;
   logic inv = 1'b0;
   logic sel_n = 1'b1;
   logic rw_n = 1'b1;
   logic [10:0] haddr = 11'h000;
   logic [7:0] hdata = 8'h00;
   logic [10:0] scan = 11'h000;
   logic [3:0] row = 4'h0;
   logic de = 1'b0;
   logic cu = 1'b0;
   logic [7:0] hrd;
   logic [7:0] rom_data;
   logic [10:0] rom_addr;
   logic hoe, buf_n, wr_n, char_clk, dot_tick, strobe_n, ser, dot_n, gate, white;
   int phi_half = 50;
   int cyc = 0;
   int num_errors = 0;
   int num_checks = 0;

   always #(SYS_PERIOD_NS / 2) sys_clk = ~sys_clk;

   // pin clocks come from the cycle count, so their phase to the system clock is fixed
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      phi2 <= ((cyc / phi_half) % 2) == 1;
      ext2 <= ((cyc / 25) % 2) == 1;
      ext12 <= (((cyc * 24) / 100) % 2) == 1;
      if (cyc == 20000)
      begin
         num_errors++;
         summarize();
      end
   end

   text_char_ram_and_dot_generator dut_u (.i_sys_clk(sys_clk), .i_arst_n(arst_n),
      .i_host_phi2(phi2), .i_ext_clk_2mhz(ext2), .i_ext_clk_12mhz(ext12),
      .i_clock_source_select(src), .i_video_invert_select(inv),
      .i_char_ram_select_n(sel_n), .i_host_read_write_n(rw_n), .i_host_addr(haddr),
      .i_host_data(hdata), .o_host_data(hrd), .o_host_data_oe(hoe),
      .o_host_buffer_enable_n(buf_n), .o_ram_write_n(wr_n), .i_scan_char_address(scan),
      .i_row_line_index(row), .i_display_active(de), .i_cursor_active(cu),
      .o_glyph_rom_addr(rom_addr), .i_glyph_rom_data(rom_data), .o_char_clk(char_clk),
      .o_dot_tick(dot_tick), .o_dot_load_strobe_n(strobe_n), .o_serial_dot_out(ser),
      .o_video_dot_n(dot_n), .o_polarity_gate(gate), .o_video_white(white));

   glyph_rom_model rom_u (.i_addr(rom_addr), .o_data(rom_data));

   task automatic summarize();
      if (num_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      num_checks++;
      if (seen !== want)
      begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic cyc1();
      @(posedge sys_clk);
      #1;
   endtask

   task automatic host(input logic rd, input logic [10:0] a, input logic [7:0] d);
      int n;
      n = 0;
      sel_n <= 1'b0;
      rw_n <= rd;
      haddr <= a;
      hdata <= d;
      while (buf_n !== 1'b0 && n < 200)
      begin
         cyc1();
         n++;
      end
      check(16'(n < 200), 16'h0001);
      check({wr_n, hoe}, {rd, rd});
      repeat (4) cyc1();
      sel_n <= 1'b1;
      repeat (8) cyc1();
      if (rd)
         check(hrd, d);
   endtask

   task automatic idle_guard();
      int bad;
      bad = 0;
      rw_n <= 1'b0;
      repeat (200)
      begin
         cyc1();
         bad += (wr_n !== 1'b1 || buf_n !== 1'b1 || hoe !== 1'b0);
      end
      check(16'(bad), 16'h0000);
      rw_n <= 1'b1;
      cyc1();
   endtask

   task automatic wait_fall();
      logic prev;
      int n;
      n = 0;
      prev = strobe_n;
      cyc1();
      while (!(prev === 1'b1 && strobe_n === 1'b0) && n < 300)
      begin
         prev = strobe_n;
         cyc1();
         n++;
      end
      check(16'(n < 300), 16'h0001);
   endtask

   task automatic measure();
      int n, lo, ticks;
      logic prev;
      wait_fall();
      n = 0;
      lo = 0;
      ticks = 0;
      prev = 1'b0;
      while (!(prev === 1'b1 && strobe_n === 1'b0) && n < 300)
      begin
         lo += (strobe_n === 1'b0);
         ticks += (dot_tick === 1'b1);
         prev = strobe_n;
         cyc1();
         n++;
      end
      check(16'(n), 16'(SYS_CLK_MHZ / CHAR_CLK_MHZ));
      check(16'(lo), 16'(LOAD_PULSE_CYCLES));
      check(16'(ticks), 16'(DOTS_PER_CHAR));
   endtask

   task automatic dots(input logic [4:0] pat, input logic on);
      int n;
      wait_fall();
      repeat (LOAD_PULSE_CYCLES) cyc1();
      check(ser, 1'b0);
      for (int k = 4; k >= 0; k--)
      begin
         n = 0;
         while (dot_tick !== 1'b1 && n < 20)
         begin
            cyc1();
            n++;
         end
         repeat (2) cyc1();
         check({ser, dot_n}, {pat[k], ~(pat[k] & on)});
      end
   endtask

   initial
   begin
      int lows;
      repeat (16) @(posedge sys_clk);
      #1;
      check({strobe_n, dot_n, buf_n, wr_n, white, char_clk, dot_tick, ser, gate, hoe},
            10'h3e0);
      arst_n <= 1'b1;
      repeat (4) cyc1();
      idle_guard();
      host(1'b0, 11'h005, 8'hc1);
      host(1'b0, 11'h405, 8'h3e);
      host(1'b1, 11'h005, 8'hc1);
      host(1'b1, 11'h405, 8'h3e);
      scan <= 11'h405;
      row <= 4'h9;
      de <= 1'b1;
      repeat (3) wait_fall();
      repeat (2) cyc1();
      check(rom_addr, {7'h3e, 4'h9});
      scan <= 11'h005;
      repeat (3) wait_fall();
      repeat (2) cyc1();
      // stored byte has its top bit set, which must not reach the code
      check(rom_addr, {7'h41, 4'h9});
      // dots of code 41 row 9 through the rom model are 1,0,1,1,1
      dots(5'h17, 1'b1);
      wait_fall();
      de <= 1'b0;
      dots(5'h17, 1'b1);
      dots(5'h17, 1'b0);
      for (int i = 0; i < 4; i++)
      begin
         {inv, cu} <= 2'(i);
         repeat (2) wait_fall();
         repeat (4) cyc1();
         check({gate, white}, {~(inv ^ cu), inv ^ cu});
      end
      {inv, cu} <= 2'h0;
      measure();
      phi_half <= 25;
      src <= SRC_PHI2_2MHZ;
      repeat (100) cyc1();
      measure();
      src <= SRC_EXTERNAL;
      repeat (100) cyc1();
      measure();
      src <= SRC_NONE;
      repeat (20) cyc1();
      lows = 0;
      repeat (200)
      begin
         cyc1();
         lows += (strobe_n !== 1'b1) + (dot_tick !== 1'b0);
      end
      check(16'(lows), 16'h0000);
      summarize();
   end
endmodule

`default_nettype wire
